/* File: irs_rstart.sv */
// Repeated start sequencer of an I2C master port.
// Assumes SCL and SDA inputs already synchronous to sys_clk, open-drain
// pins resolved outside, and software control bits as plain ports.
// Function
// - A repeat-start request taken while idle drives SCL low.
// - With SCL seen low, the baud generator is loaded and SDA released.
// - On expiry with SDA high, SCL is released.
// - With SCL seen high, the generator reloads; both lines stay high.
// - After that period SDA is driven low for one period, SCL high.
// - Then SCL goes low, the request clears, SDA stays low, no reload.
// - The start-detected bit is set when a start is seen on the lines.
// - The interrupt flag rises only after the final period expires.
// - A request while another bus event runs is ignored.
// - SDA low as SCL rises is a bus collision.
// - SCL low before SDA is driven low is a bus collision.
`timescale 1ns/1ns
`default_nettype none
module irs_rstart
  import irs_pkg::*;
#(
  parameter int BRG_W = IRS_BRG_W
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [BRG_W-1:0] baud_reload,
  input wire logic repeat_start_request_set,
  input wire logic other_event_busy,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic start_seen_clr,
  input wire logic port_irq_flag_clr,
  input wire logic collision_clr,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic repeat_start_request,
  output logic start_seen,
  output logic port_irq_flag,
  output logic bus_collision,
  output logic busy
);
  if (BRG_W < 2) begin : g_bad_width
    $error("irs_rstart: baud width too small");
  end

  typedef enum logic [2:0] {
    S_IDLE,
    S_SCL_LO,
    S_SDA_HI,
    S_SCL_REL,
    S_BOTH_HI,
    S_SDA_LO
  } irs_state_e;

  // Phases in which the sequencer leaves SCL to the pull-up.
  function automatic logic irs_scl_free(input irs_state_e s);
    return s == S_SCL_REL || s == S_BOTH_HI || s == S_SDA_LO;
  endfunction : irs_scl_free

  // Phases in which SDA is left released while the lines are watched.
  function automatic logic irs_sda_free(input irs_state_e s);
    return s == S_SDA_HI || s == S_SCL_REL || s == S_BOTH_HI;
  endfunction : irs_sda_free

  typedef struct packed {
    irs_state_e st;
    logic req;
    logic scl_drv;
    logic sda_drv;
    logic start_seen;
    logic irq;
    logic coll;
    logic scl_prev;
    logic sda_prev;
  } irs_top_s;

  irs_top_s q;
  irs_top_s d;
  logic brg_load;
  logic brg_exp;
  logic coll_ev;

  irs_brg #(.W(BRG_W)) u_brg (
    .sys_clk(sys_clk),
    .srst(srst),
    .load(brg_load),
    .reload(baud_reload),
    .expired(brg_exp)
  );

  // Pins are open-drain: only a low is ever driven.
  assign scl_out = IRS_LINE_LOW;
  assign sda_out = IRS_LINE_LOW;
  assign scl_oe = q.scl_drv;
  assign sda_oe = q.sda_drv;
  assign repeat_start_request = q.req;
  assign start_seen = q.start_seen;
  assign port_irq_flag = q.irq;
  assign bus_collision = q.coll;
  assign busy = (q.st != S_IDLE);

  logic scl_rise;
  logic start_cond;
  assign scl_rise = scl_in && !q.scl_prev;
  assign start_cond = scl_in && q.scl_prev && q.sda_prev && !sda_in;

  always_comb begin
    d = q;
    brg_load = 1'b0;
    coll_ev = 1'b0;
    d.scl_prev = scl_in;
    d.sda_prev = sda_in;
    // Software clears lose to a same-cycle hardware set below.
    if (start_seen_clr) d.start_seen = 1'b0;
    if (port_irq_flag_clr) d.irq = 1'b0;
    if (collision_clr) d.coll = 1'b0;
    if (start_cond) d.start_seen = 1'b1;
    unique case (q.st)
      S_IDLE: begin
        if (repeat_start_request_set && !other_event_busy) begin
          d.req = 1'b1;
          d.scl_drv = 1'b1;
          d.st = S_SCL_LO;
        end
      end
      S_SCL_LO: begin
        if (!scl_in) begin
          brg_load = 1'b1;
          d.sda_drv = 1'b0;
          d.st = S_SDA_HI;
        end
      end
      S_SDA_HI: begin
        if (brg_exp && sda_in) begin
          d.scl_drv = 1'b0;
          d.st = S_SCL_REL;
        end else if (brg_exp) begin
          // SDA held low here would still be low as SCL rises, and the
          // generator has stopped, so waiting would hang the sequence.
          coll_ev = 1'b1;
        end
      end
      S_SCL_REL: begin
        if (scl_rise && !sda_in) begin
          coll_ev = 1'b1;
        end else if (scl_in) begin
          brg_load = 1'b1;
          d.st = S_BOTH_HI;
        end
      end
      S_BOTH_HI: begin
        if (!scl_in) begin
          coll_ev = 1'b1;
        end else if (brg_exp) begin
          d.sda_drv = 1'b1;
          brg_load = 1'b1;
          d.st = S_SDA_LO;
        end
      end
      S_SDA_LO: begin
        // No reload: the expiry of this period is the last one, so the
        // flag rises with it and SDA is simply left held low.
        if (brg_exp) begin
          d.scl_drv = 1'b1;
          d.req = 1'b0;
          d.irq = 1'b1;
          d.st = S_IDLE;
        end
      end
    endcase
    // A lost arbitration frees both lines at once so the winner is not
    // disturbed; this does not depend on the sticky flag being clear.
    if (coll_ev) begin
      d.coll = 1'b1;
      d.scl_drv = 1'b0;
      d.sda_drv = 1'b0;
      d.req = 1'b0;
      d.st = S_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q <= '{st: S_IDLE, scl_prev: 1'b1, sda_prev: 1'b1, default: 1'b0};
    end else begin
      q <= d;
    end
  end

  // Sequence steps, with one check or more for each rule of the sequencer.
  chk_scl_first: assert property (
    @(posedge sys_clk) disable iff (srst)
    q.st == S_IDLE && repeat_start_request_set && !other_event_busy
    |=> scl_oe && repeat_start_request)
    else $error("SCL not driven on request");

  chk_req_ignored: assert property (
    @(posedge sys_clk) disable iff (srst)
    q.st == S_IDLE && !q.req && other_event_busy |=> !busy)
    else $error("Request taken while busy");

  chk_idle_quiet: assert property (
    @(posedge sys_clk) disable iff (srst)
    q.st == S_IDLE && !(repeat_start_request_set && !other_event_busy)
    |=> $stable(scl_oe) && $stable(sda_oe) && !busy)
    else $error("Lines moved while idle");

  chk_sda_release: assert property (
    @(posedge sys_clk) disable iff (srst)
    q.st == S_SCL_LO && !scl_in |=> !sda_oe && q.st == S_SDA_HI)
    else $error("SDA not released");

  chk_sda_free: assert property (
    @(posedge sys_clk) disable iff (srst)
    irs_sda_free(q.st) |-> !sda_oe)
    else $error("SDA driven while it should be free");

  chk_scl_release: assert property (
    @(posedge sys_clk) disable iff (srst)
    q.st == S_SDA_HI && brg_exp && sda_in |=> !scl_oe)
    else $error("SCL not released");

  chk_scl_free: assert property (
    @(posedge sys_clk) disable iff (srst)
    irs_scl_free(q.st) |-> !scl_oe)
    else $error("SCL driven while it should be free");

  chk_sda_expiry: assert property (
    @(posedge sys_clk) disable iff (srst)
    q.st == S_SDA_HI && brg_exp && !sda_in
    |=> bus_collision && !scl_oe && !sda_oe && !busy)
    else $error("Low SDA at expiry not flagged");

  chk_reload_high: assert property (
    @(posedge sys_clk) disable iff (srst)
    q.st == S_SCL_REL && scl_in && sda_in |-> brg_load)
    else $error("No reload at SCL high");

  chk_sda_low: assert property (
    @(posedge sys_clk) disable iff (srst)
    q.st == S_BOTH_HI && scl_in && brg_exp |=> sda_oe && !scl_oe)
    else $error("SDA not driven low");

  chk_finish: assert property (
    @(posedge sys_clk) disable iff (srst)
    q.st == S_SDA_LO && brg_exp
    |-> !brg_load ##1 (scl_oe && sda_oe && !q.req && !busy))
    else $error("Finish wrong");

  chk_start_seen: assert property (
    @(posedge sys_clk) disable iff (srst)
    start_cond |=> start_seen)
    else $error("Start not flagged");

  chk_irq_late: assert property (
    @(posedge sys_clk) disable iff (srst)
    $rose(port_irq_flag) |-> $past(q.st) == S_SDA_LO && $past(brg_exp))
    else $error("Interrupt too early");

  chk_irq_set: assert property (
    @(posedge sys_clk) disable iff (srst)
    q.st == S_SDA_LO && brg_exp |=> port_irq_flag)
    else $error("Interrupt missing at end");

  chk_irq_hold: assert property (
    @(posedge sys_clk) disable iff (srst)
    port_irq_flag && !port_irq_flag_clr |=> port_irq_flag)
    else $error("Interrupt flag lost");

  chk_coll_rise: assert property (
    @(posedge sys_clk) disable iff (srst)
    q.st == S_SCL_REL && scl_rise && !sda_in
    |=> bus_collision && !scl_oe && !sda_oe && !busy)
    else $error("Rise collision missed");

  chk_coll_low: assert property (
    @(posedge sys_clk) disable iff (srst)
    q.st == S_BOTH_HI && !scl_in |=> bus_collision && !busy)
    else $error("Low SCL collision missed");

  chk_coll_set: assert property (
    @(posedge sys_clk) disable iff (srst)
    coll_ev |=> bus_collision && !repeat_start_request && !busy)
    else $error("Collision not abandoned");

  chk_coll_hold: assert property (
    @(posedge sys_clk) disable iff (srst)
    bus_collision && !collision_clr |=> bus_collision)
    else $error("Collision flag lost");

  chk_coll_idle: assert property (
    @(posedge sys_clk) disable iff (srst)
    $rose(bus_collision) |-> !repeat_start_request)
    else $error("Request kept after collision");

  // Scenarios that the bench is meant to reach.
  cov_done: cover property (@(posedge sys_clk) disable iff (srst)
    $rose(port_irq_flag));

  cov_coll: cover property (@(posedge sys_clk) disable iff (srst)
    $rose(bus_collision));

  cov_ignored: cover property (@(posedge sys_clk) disable iff (srst)
    repeat_start_request_set && other_event_busy && !busy);

  cov_stretch: cover property (@(posedge sys_clk) disable iff (srst)
    irs_scl_free(q.st) && !scl_in);

  cov_sda_fault: cover property (@(posedge sys_clk) disable iff (srst)
    irs_sda_free(q.st) && !sda_in);
endmodule : irs_rstart
`default_nettype wire

/* File: irs_pkg.sv */
// Package for the I2C master repeated start sequencer.
// Holds timing counts, field widths and reset values shared by the design.
package irs_pkg;
  localparam int IRS_CLK_HZ = 50000000;
  localparam int IRS_BRG_W = 8;
  localparam logic [7:0] IRS_BRG_RELOAD_DEF = 8'h13;
  localparam logic [7:0] IRS_BRG_ZERO = 8'h00;
  localparam logic IRS_LINE_HIGH = 1'b1;
  localparam logic IRS_LINE_LOW = 1'b0;
endpackage : irs_pkg

/* File: irs_brg.sv */
// Baud rate generator for the repeated start sequencer.
// Assumes a synchronous active-high reset and a single system clock.
`timescale 1ns/1ns
`default_nettype none
module irs_brg
  import irs_pkg::*;
#(
  parameter int W = IRS_BRG_W
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [W-1:0] reload,
  output logic expired
);
  if (W < 2) begin : g_bad_width
    $error("irs_brg: width too small");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
  } irs_brg_s;

  irs_brg_s st_q;
  irs_brg_s st_d;

  // The count reaches zero once per baud period after a load.
  always_comb begin
    st_d = st_q;
    expired = st_q.run && (st_q.cnt == '0);
    if (load) begin
      st_d.cnt = reload;
      st_d.run = 1'b1;
    end else if (st_q.run) begin
      if (st_q.cnt == '0) begin
        st_d.run = 1'b0;
      end else begin
        st_d.cnt = st_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : irs_brg
`default_nettype wire

/* File: irs_bus_model.sv */
// Pulled-up I2C bus with a slave that may stretch SCL and force SDA low.
// Assumes the sequencer's enables pull the lines low when high.
`timescale 1ns/1ns
`default_nettype none
module irs_bus_model (
  input wire logic sys_clk,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic hold_scl,
  input wire logic hold_sda,
  input wire logic [3:0] stretch,
  output logic scl_in,
  output logic sda_in
);
  logic [3:0] cnt_q = 4'h0;
  // A slow slave keeps SCL low for a while after the master lets go.
  always @(posedge sys_clk) begin
    if (scl_oe) cnt_q <= 4'h0;
    else if (cnt_q < stretch) cnt_q <= cnt_q + 4'h1;
  end
  assign scl_in = !(scl_oe || hold_scl || cnt_q < stretch);
  assign sda_in = !(sda_oe || hold_sda);
endmodule : irs_bus_model
`default_nettype wire

/* File: i2c_master_repeated_start_tb_top.sv */
// Self-checking bench of the repeated start sequencer.
// Assumes the bus model resolves both open-drain lines.
`timescale 1ns/1ns
`default_nettype none
module i2c_master_repeated_start_tb_top;
  import irs_pkg::*;
  logic sys_clk = 0, srst = 1, set = 0, obusy = 0, hs = 0, hc = 0, clr = 0;
  logic [7:0] rl = IRS_BRG_RELOAD_DEF, rnd = 8'h05;
  logic [3:0] st = 4'h0;
  logic scl_oe, sda_oe, scl_in, sda_in, req, ss, irq, col, busy;
  int n_errors = 0, tests_run = 0;
  initial forever #10 sys_clk = ~sys_clk;
  irs_rstart dut_u (.sys_clk(sys_clk), .srst(srst), .baud_reload(rl),
    .repeat_start_request_set(set), .other_event_busy(obusy),
    .scl_in(scl_in), .sda_in(sda_in), .start_seen_clr(clr),
    .port_irq_flag_clr(clr), .collision_clr(clr), .scl_out(),
    .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe),
    .repeat_start_request(req), .start_seen(ss), .port_irq_flag(irq),
    .bus_collision(col), .busy(busy));
  irs_bus_model bus_u (.sys_clk(sys_clk), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .hold_scl(hc), .hold_sda(hs), .stretch(st), .scl_in(scl_in),
    .sda_in(sda_in));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : cyc
  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_cnt(input string nm, input logic [8:0] e,
                         input logic [8:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_cnt
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic kick;
    set = 1;
    cyc(1);
    set = 0;
  endtask : kick
  task automatic run_seq(input logic [7:0] r);
    logic [8:0] n;
    n = 9'h000;
    rl = r;
    st = rnd[3:0] & 4'h3;
    kick();
    chk_bit("scl_oe", 1'b1, scl_oe);
    chk_bit("request", 1'b1, req);
    repeat (3000) if (busy === 1'b1) begin
      n = n + {8'h00, sda_oe && !scl_oe};
      if (irq !== 1'b0) chk_bit("irq_early", 1'b0, irq);
      cyc(1);
    end
    chk_cnt("sda_low_span", {1'b0, r} + 9'h001, n);
    chk_bit("irq", 1'b1, irq);
    chk_bit("start_seen", 1'b1, ss);
    chk_bit("request", 1'b0, req);
    chk_bit("scl_oe", 1'b1, scl_oe);
    chk_bit("sda_oe", 1'b1, sda_oe);
    chk_bit("collision", 1'b0, col);
    $display("test seq reload %0d done", r);
  endtask : run_seq
  task automatic collide(input int mode);
    st = 4'h2;
    kick();
    // Mode 2 pulls SDA while it is released and SCL is still driven low.
    repeat (3000) if (busy === 1'b1 && mode == 2 && sda_oe !== 1'b0) cyc(1);
    // Mode 0 forces SDA while SCL is still stretched, so it is low at the
    // rise; mode 1 waits for SCL high and lets one edge see it high.
    repeat (3000) if (busy === 1'b1 && mode < 2 && (scl_oe !== 1'b0 ||
      (mode == 1 && scl_in !== 1'b1))) cyc(1);
    if (mode == 1) begin
      cyc(1);
      hc = 1;
    end else begin
      hs = 1;
    end
    repeat (3000) if (col !== 1'b1) cyc(1);
    cyc(1);
    chk_bit("collision", 1'b1, col);
    chk_bit("irq", 1'b0, irq);
    chk_bit("scl_oe", 1'b0, scl_oe);
    chk_bit("sda_oe", 1'b0, sda_oe);
    chk_bit("request", 1'b0, req);
    chk_bit("busy", 1'b0, busy);
    hs = 0;
    hc = 0;
    $display("test collision %0d done", mode);
  endtask : collide
  task automatic clear_all;
    clr = 1;
    cyc(1);
    clr = 0;
    cyc(1);
    chk_bit("start_seen", 1'b0, ss);
    chk_bit("irq", 1'b0, irq);
    chk_bit("collision", 1'b0, col);
  endtask : clear_all
  initial begin
    cyc(5);
    srst = 0;
    chk_bit("busy", 1'b0, busy);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      run_seq(i == 0 ? 8'h00 : i == 1 ? IRS_BRG_RELOAD_DEF : rnd & 8'h1F);
      clear_all();
    end
    collide(0);
    clear_all();
    collide(1);
    clear_all();
    collide(2);
    obusy = 1;
    kick();
    cyc(2);
    chk_bit("busy", 1'b0, busy);
    chk_bit("request", 1'b0, req);
    chk_bit("scl_oe", 1'b0, scl_oe);
    $display("test ignored request done");
    wrap_up();
  end
  initial begin
    #1000000;
    n_errors++;
    wrap_up();
  end
endmodule : i2c_master_repeated_start_tb_top
`default_nettype wire
